// ===== core/lcdtoc_pkg.sv
/*
 * lcdtoc_pkg: register map, field positions, reset values and shared types
 * for the display timing and output control block.
 * assumes a 32-bit classic wishbone slave with word-aligned registers.
 */
package lcdtoc_pkg;
    localparam int          ADDR_W          = 8;
    localparam logic [7:0]  OFF_MODE        = 8'h00;
    localparam logic [7:0]  OFF_CLKCON      = 8'h04;
    localparam logic [7:0]  OFF_BGCOLOR     = 8'h08;
    localparam logic [7:0]  OFF_RES         = 8'h0C;
    localparam logic [7:0]  OFF_FPORCH      = 8'h10;
    localparam logic [7:0]  OFF_SYNCW       = 8'h14;
    localparam logic [7:0]  OFF_BPORCH      = 8'h18;
    localparam logic [7:0]  OFF_POINTER     = 8'h1C;
    localparam logic [7:0]  OFF_STATUS      = 8'h20;

    localparam logic [31:0] MASK_MODE       = 32'hDDD8_03E0;
    localparam logic [31:0] MASK_CLKCON     = 32'h0000_3F3F;
    localparam logic [31:0] MASK_PAIR       = 32'h07FF_07FF;
    localparam logic [31:0] RESET_VAL       = 32'h0000_0000;

    localparam int B_MODULE_ON   = 31;
    localparam int B_POINTER_ON  = 30;
    localparam int B_VS_POL      = 28;
    localparam int B_HS_POL      = 27;
    localparam int B_DV_POL      = 26;
    localparam int B_DITHER      = 24;
    localparam int B_VS_SINGLE   = 23;
    localparam int B_PCLK_POL    = 22;
    localparam int B_GAMMA_ON    = 20;
    localparam int B_BLANK_FORCE = 19;
    localparam int B_YUV_SEL     = 9;
    localparam int B_FMT_UNDIV   = 8;
    localparam int B_SEQ_LO      = 5;
    localparam int B_FETCH_LO    = 8;
    localparam int B_DIV_LO      = 0;
    localparam int B_X_LO        = 16;
    localparam int B_Y_LO        = 0;

    localparam logic [2:0] SEQ_BT656 = 3'h7;
    localparam logic [2:0] SEQ_YUYV  = 3'h6;
    localparam logic [2:0] SEQ_RGB   = 3'h0;
    localparam logic [5:0] DIV_MAX   = 6'h1F;
    localparam logic [5:0] FETCH_MAX = 6'h20;

    typedef enum logic [1:0] {
        PH_ACTIVE = 2'b00,
        PH_FRONT  = 2'b01,
        PH_SYNC   = 2'b10,
        PH_BACK   = 2'b11
    } lcdtoc_phase_e;

    typedef struct packed {
        logic        hsync;
        logic        vsync;
        logic        de;
        logic        pclk;
        logic [23:0] rgb;
    } lcdtoc_pins_s;

    typedef struct packed {
        logic [31:0] mode;
        logic [31:0] clkcon;
        logic [31:0] bg;
        logic [31:0] res;
        logic [31:0] fp;
        logic [31:0] sw;
        logic [31:0] bp;
        logic [31:0] ptr;
    } lcdtoc_regs_s;

    typedef struct packed {
        lcdtoc_regs_s  r;
        logic          ack;
        logic [31:0]   dat;
        logic [5:0]    div_cnt;
        logic          pix_en;
        logic          pclk;
        lcdtoc_phase_e hph;
        lcdtoc_phase_e vph;
        logic [10:0]   hcnt;
        logic [10:0]   vcnt;
        logic          line_start;
        logic          dither_ph;
        lcdtoc_pins_s  pins;
    } lcdtoc_state_s;
endpackage

// ===== core/lcdtoc_top.sv
/*
 * lcdtoc_top: mode and timing registers, pixel clock divider and raster
 * timing generator driving a parallel display panel.
 * assumes one 100 MHz clock as the reference, classic wishbone master,
 * pixel data from layers arrives elsewhere; here the background fills.
 */
// The register offsets and the Wishbone interface to the registers were chosen for this implementation.
// Functional notes
// - module enable bit 31 gates operation
// - bit 30 enables pointer overlay
// - bits 28,27,26 invert vsync, hsync, de
// - bit 24 enables output dithering
// - bit 23: vsync one cycle per line
// - bit 22 inverts outgoing pixel clock
// - bit 20 enables gamma ramp
// - bit 19 forces blank pixel output
// - bit 9 selects yuv versus rgb
// - bit 8 leaves format clock undivided
// - bits 7-5 select output sequence format
// - bits 13-8 line prefetch, max 32
// - bits 5-0 divide reference clock 1..31
// - even divisor 50%, odd from 3 up: ceil(3/5 of divisor) high
// - background colour rgba in four bytes
// - background bytes 31-8 drive the rgb pixels
// - resolution: width 26-16, height 10-0
// - front porch fields after active region
// - horizontal sync width field 26-16
// - vertical sync lines field 10-0
// - back porch fields after sync pulse
// - unimplemented bits read zero, reset zero
// - pointer position column and row fields
`timescale 1ns/1ps
`default_nettype none
module lcdtoc_top (
    input  wire logic                         I_MCLK,
    input  wire logic                         I_RESETN,
    input  wire logic                         I_WB_CYC,
    input  wire logic                         I_WB_STB,
    input  wire logic                         I_WB_WE,
    input  wire logic [lcdtoc_pkg::ADDR_W-1:0] I_WB_ADR,
    input  wire logic [3:0]                   I_WB_SEL,
    input  wire logic [31:0]                  I_WB_DAT,
    output logic      [31:0]                  O_WB_DAT,
    output logic                              O_WB_ACK,
    output logic                              O_HSYNC,
    output logic                              O_VSYNC,
    output logic                              O_DE,
    output logic                              O_PCLK,
    output logic      [23:0]                  O_RGB,
    output logic                              O_POINTER_ON,
    output logic                              O_GAMMA_ON,
    output logic                              O_YUV_SEL,
    output logic                              O_FMT_UNDIV,
    output logic      [2:0]                   O_SEQ_SEL,
    output logic      [5:0]                   O_FETCH_LINES,
    output logic                              O_FRAME_START
);
    import lcdtoc_pkg::*;

    lcdtoc_state_s s_q;
    lcdtoc_state_s s_d;

    logic        en;
    logic [5:0]  div;
    logic [5:0]  hi_cnt;
    logic [10:0] hlen;
    logic [10:0] vlen;
    logic        line_end;
    logic [23:0] pix;
    logic [31:0] wmask;
    logic [31:0] rdat;
    logic [31:0] status;

    always_comb begin
        en  = s_q.r.mode[B_MODULE_ON];
        div = s_q.r.clkcon[B_DIV_LO +: 6];
        // even: half high; odd: ceil(3/5) of the period high, close to 60/40
        if (div[0]) begin
            hi_cnt = 6'((7'(div) * 7'd3 + 7'd4) / 7'd5);
        end else begin
            hi_cnt = div >> 1;
        end
        case (s_q.hph)
            PH_ACTIVE: hlen = s_q.r.res[B_X_LO +: 11];
            PH_FRONT:  hlen = s_q.r.fp[B_X_LO +: 11];
            PH_SYNC:   hlen = s_q.r.sw[B_X_LO +: 11];
            default:   hlen = s_q.r.bp[B_X_LO +: 11];
        endcase
        case (s_q.vph)
            PH_ACTIVE: vlen = s_q.r.res[B_Y_LO +: 11];
            PH_FRONT:  vlen = s_q.r.fp[B_Y_LO +: 11];
            PH_SYNC:   vlen = s_q.r.sw[B_Y_LO +: 11];
            default:   vlen = s_q.r.bp[B_Y_LO +: 11];
        endcase
        line_end = 1'b0;
        if (s_q.hph == PH_BACK) begin
            line_end = (s_q.hcnt + 11'd1 >= s_q.r.bp[B_X_LO +: 11]);
        end
        // background fills where no layer covers; bytes 31-8 of the colour word give the rgb
        pix = s_q.r.bg[31:8];
        if (s_q.r.mode[B_DITHER] && s_q.dither_ph && pix[0] == 1'b0) begin
            pix = pix | 24'h01_0101;
        end
        wmask = {{8{I_WB_SEL[3]}}, {8{I_WB_SEL[2]}}, {8{I_WB_SEL[1]}}, {8{I_WB_SEL[0]}}};
        status = {28'h000_0000, s_q.vph == PH_ACTIVE, s_q.hph == PH_ACTIVE,
                  s_q.pins.vsync, s_q.pins.hsync};
        case (I_WB_ADR)
            OFF_MODE:    rdat = s_q.r.mode;
            OFF_CLKCON:  rdat = s_q.r.clkcon;
            OFF_BGCOLOR: rdat = s_q.r.bg;
            OFF_RES:     rdat = s_q.r.res;
            OFF_FPORCH:  rdat = s_q.r.fp;
            OFF_SYNCW:   rdat = s_q.r.sw;
            OFF_BPORCH:  rdat = s_q.r.bp;
            OFF_POINTER: rdat = s_q.r.ptr;
            OFF_STATUS:  rdat = status;
            default:     rdat = 32'h0000_0000;
        endcase
    end

    function automatic logic [31:0] wr(input logic [31:0] old, input logic [31:0] nw,
                                       input logic [31:0] bm, input logic [31:0] keep);
        wr = ((old & ~bm) | (nw & bm)) & keep;
    endfunction

    always_comb begin
        s_d = s_q;
        // bus: ack one cycle after a request, dropped the cycle after
        s_d.ack = 1'b0;
        if (I_WB_CYC && I_WB_STB && !s_q.ack) begin
            s_d.ack = 1'b1;
            s_d.dat = rdat;
            if (I_WB_WE) begin
                case (I_WB_ADR)
                    OFF_MODE:    s_d.r.mode   = wr(s_q.r.mode, I_WB_DAT, wmask, MASK_MODE);
                    OFF_CLKCON: begin
                        s_d.r.clkcon = wr(s_q.r.clkcon, I_WB_DAT, wmask, MASK_CLKCON);
                        // reserved divisors and over-long prefetch are clamped
                        if (s_d.r.clkcon[B_DIV_LO +: 6] > DIV_MAX) begin
                            s_d.r.clkcon[B_DIV_LO +: 6] = DIV_MAX;
                        end
                        if (s_d.r.clkcon[B_FETCH_LO +: 6] > FETCH_MAX) begin
                            s_d.r.clkcon[B_FETCH_LO +: 6] = FETCH_MAX;
                        end
                    end
                    OFF_BGCOLOR: s_d.r.bg     = wr(s_q.r.bg, I_WB_DAT, wmask, 32'hFFFF_FFFF);
                    OFF_RES:     s_d.r.res    = wr(s_q.r.res, I_WB_DAT, wmask, MASK_PAIR);
                    OFF_FPORCH:  s_d.r.fp     = wr(s_q.r.fp, I_WB_DAT, wmask, MASK_PAIR);
                    OFF_SYNCW:   s_d.r.sw     = wr(s_q.r.sw, I_WB_DAT, wmask, MASK_PAIR);
                    OFF_BPORCH:  s_d.r.bp     = wr(s_q.r.bp, I_WB_DAT, wmask, MASK_PAIR);
                    OFF_POINTER: s_d.r.ptr    = wr(s_q.r.ptr, I_WB_DAT, wmask, MASK_PAIR);
                    default: ;
                endcase
            end
        end

        // pixel clock divider; divisor 0 or 1 gives one pixel per clock
        s_d.pix_en = 1'b0;
        if (!en) begin
            s_d.div_cnt = 6'h00;
            s_d.pclk    = 1'b0;
        end else if (div <= 6'h01) begin
            s_d.pix_en = 1'b1;
            s_d.pclk   = ~s_q.pclk;
        end else begin
            if (s_q.div_cnt + 6'h01 >= div) begin
                s_d.div_cnt = 6'h00;
                s_d.pix_en  = 1'b1;
            end else begin
                s_d.div_cnt = s_q.div_cnt + 6'h01;
            end
            s_d.pclk = (s_d.div_cnt < hi_cnt);
        end

        // raster walk, a phase of zero length still lasts one pixel (one line for vertical phases), as length 1 does
        s_d.line_start = 1'b0;
        if (!en) begin
            s_d.hph  = PH_ACTIVE;
            s_d.vph  = PH_ACTIVE;
            s_d.hcnt = 11'h000;
            s_d.vcnt = 11'h000;
        end else if (s_q.pix_en) begin
            s_d.dither_ph = ~s_q.dither_ph;
            if (s_q.hcnt + 11'd1 >= hlen || hlen == 11'h000) begin
                s_d.hcnt = 11'h000;
                s_d.hph  = lcdtoc_phase_e'(s_q.hph + 2'b01);
                if (line_end) begin
                    s_d.line_start = 1'b1;
                    s_d.dither_ph  = ~s_q.vcnt[0];
                    if (s_q.vcnt + 11'd1 >= vlen || vlen == 11'h000) begin
                        s_d.vcnt = 11'h000;
                        s_d.vph  = lcdtoc_phase_e'(s_q.vph + 2'b01);
                    end else begin
                        s_d.vcnt = s_q.vcnt + 11'd1;
                    end
                end
            end else begin
                s_d.hcnt = s_q.hcnt + 11'd1;
            end
        end

        // pins: active-level computed, then polarity applied
        s_d.pins.de    = (s_q.hph == PH_ACTIVE) && (s_q.vph == PH_ACTIVE) && en;
        s_d.pins.hsync = (s_q.hph == PH_SYNC) && en;
        if (s_q.r.mode[B_VS_SINGLE]) begin
            s_d.pins.vsync = (s_q.vph == PH_SYNC) && s_q.line_start && en;
        end else begin
            s_d.pins.vsync = (s_q.vph == PH_SYNC) && en;
        end
        s_d.pins.de    = s_d.pins.de    ^ s_q.r.mode[B_DV_POL];
        s_d.pins.hsync = s_d.pins.hsync ^ s_q.r.mode[B_HS_POL];
        s_d.pins.vsync = s_d.pins.vsync ^ s_q.r.mode[B_VS_POL];
        s_d.pins.pclk  = s_q.pclk ^ s_q.r.mode[B_PCLK_POL];
        if (!en || s_q.r.mode[B_BLANK_FORCE] || s_q.hph != PH_ACTIVE ||
            s_q.vph != PH_ACTIVE) begin
            s_d.pins.rgb = 24'h00_0000;
        end else begin
            s_d.pins.rgb = pix;
        end
    end

    always_ff @(posedge I_MCLK or negedge I_RESETN) begin
        if (!I_RESETN) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    // plain level controls for the formatter and fetch engine downstream, and the one-cycle frame start pulse
    logic       ptr_q;
    logic       gam_q;
    logic       yuv_q;
    logic       fmt_q;
    logic [2:0] seq_q;
    logic [5:0] fetch_q;
    logic       fs_q;

    always_ff @(posedge I_MCLK or negedge I_RESETN) begin
        if (!I_RESETN) begin
            ptr_q   <= 1'b0;
            gam_q   <= 1'b0;
            yuv_q   <= 1'b0;
            fmt_q   <= 1'b0;
            seq_q   <= 3'h0;
            fetch_q <= 6'h00;
            fs_q    <= 1'b0;
        end else begin
            ptr_q   <= en && s_q.r.mode[B_POINTER_ON];
            gam_q   <= en && s_q.r.mode[B_GAMMA_ON];
            yuv_q   <= s_q.r.mode[B_YUV_SEL];
            fmt_q   <= s_q.r.mode[B_FMT_UNDIV];
            // reserved sequence codes fall back to parallel rgb
            if (s_q.r.mode[B_SEQ_LO +: 3] == SEQ_BT656 ||
                s_q.r.mode[B_SEQ_LO +: 3] == SEQ_YUYV) begin
                seq_q <= s_q.r.mode[B_SEQ_LO +: 3];
            end else begin
                seq_q <= SEQ_RGB;
            end
            fetch_q <= s_q.r.clkcon[B_FETCH_LO +: 6];
            // the wrap from vertical back porch is only visible in the next state
            fs_q    <= s_d.line_start && s_q.vph == PH_BACK && s_d.vph == PH_ACTIVE;
        end
    end

    assign O_WB_DAT      = s_q.dat;
    assign O_WB_ACK      = s_q.ack;
    assign O_HSYNC       = s_q.pins.hsync;
    assign O_VSYNC       = s_q.pins.vsync;
    assign O_DE          = s_q.pins.de;
    assign O_PCLK        = s_q.pins.pclk;
    assign O_RGB         = s_q.pins.rgb;
    assign O_POINTER_ON  = ptr_q;
    assign O_GAMMA_ON    = gam_q;
    assign O_YUV_SEL     = yuv_q;
    assign O_FMT_UNDIV   = fmt_q;
    assign O_SEQ_SEL     = seq_q;
    assign O_FETCH_LINES = fetch_q;
    assign O_FRAME_START = fs_q;
endmodule // lcdtoc_top
`default_nettype wire

// ===== tb/lcdtoc_checker.sv
/* lcdtoc_checker: port-level assertions on lcdtoc_top, bound at the foot.
   assumes one clock, async active-low reset and a classic wishbone master. */
`timescale 1ns/1ps
`default_nettype none
module lcdtoc_checker
    import lcdtoc_pkg::*;
(
    input wire logic                          I_MCLK,
    input wire logic                          I_RESETN,
    input wire logic                          I_WB_CYC,
    input wire logic                          I_WB_STB,
    input wire logic                          I_WB_WE,
    input wire logic [lcdtoc_pkg::ADDR_W-1:0] I_WB_ADR,
    input wire logic [3:0]                    I_WB_SEL,
    input wire logic [31:0]                   I_WB_DAT,
    input wire logic                          O_WB_ACK,
    input wire logic                          O_HSYNC,
    input wire logic                          O_VSYNC,
    input wire logic                          O_DE,
    input wire logic                          O_PCLK,
    input wire logic [23:0]                   O_RGB,
    input wire logic                          O_POINTER_ON,
    input wire logic                          O_GAMMA_ON,
    input wire logic                          O_YUV_SEL,
    input wire logic                          O_FMT_UNDIV,
    input wire logic [2:0]                    O_SEQ_SEL,
    input wire logic [5:0]                    O_FETCH_LINES,
    input wire logic                          O_FRAME_START
);
    logic [31:0] mode_q;
    // shadow of the mode register, committed at the edge where ack is sampled
    always_ff @(posedge I_MCLK or negedge I_RESETN) begin
        if (!I_RESETN) begin
            mode_q <= RESET_VAL;
        end else if (O_WB_ACK && I_WB_CYC && I_WB_STB && I_WB_WE && I_WB_ADR == OFF_MODE) begin
            for (int b = 0; b < 4; b++) begin
                if (I_WB_SEL[b]) begin
                    mode_q[8*b +: 8] <= I_WB_DAT[8*b +: 8];
                end
            end
        end
    end
    default clocking cb @(posedge I_MCLK); endclocking
    default disable iff (!I_RESETN);
    sequence s_taken;
        I_WB_CYC && I_WB_STB && !O_WB_ACK;
    endsequence
    sequence s_ack_pulse;
        O_WB_ACK ##1 !O_WB_ACK;
    endsequence
    property p_ack_after;
        s_taken |=> s_ack_pulse;
    endproperty
    property p_ack_cause;
        $rose(O_WB_ACK) |-> $past(I_WB_CYC && I_WB_STB);
    endproperty
    property p_seq;
        $stable(mode_q) [*2] |-> O_SEQ_SEL == ((mode_q[7:5] >= 3'h6) ? mode_q[7:5] : 3'h0);
    endproperty
    property p_blank;
        mode_q[B_BLANK_FORCE] [*3] |-> O_RGB == 24'h00_0000;
    endproperty
    property p_off;
        (!mode_q[B_MODULE_ON] && $stable(mode_q)) [*3] |-> O_RGB == 24'h00_0000
            && O_DE == mode_q[B_DV_POL] && O_HSYNC == mode_q[B_HS_POL]
            && O_VSYNC == mode_q[B_VS_POL] && O_PCLK == mode_q[B_PCLK_POL];
    endproperty
    property p_frame;
        O_FRAME_START |-> $past(mode_q[B_MODULE_ON], 2) ##1 !O_FRAME_START;
    endproperty
    property p_fetch;
        O_FETCH_LINES <= FETCH_MAX;
    endproperty
    property p_gamma;
        $stable(mode_q) [*2] |-> O_GAMMA_ON == (mode_q[B_MODULE_ON] && mode_q[B_GAMMA_ON]);
    endproperty
    property p_pointer;
        $stable(mode_q) [*2] |-> O_POINTER_ON == (mode_q[B_MODULE_ON] && mode_q[B_POINTER_ON]);
    endproperty
    property p_fmt;
        $stable(mode_q) [*2] |-> {O_YUV_SEL, O_FMT_UNDIV} == mode_q[9:8];
    endproperty
    a_ack_after: assert property (p_ack_after)
        else $error("ack missing one cycle after request");
    a_ack_cause: assert property (p_ack_cause)
        else $error("ack without request");
    a_seq: assert property (p_seq)
        else $error("output sequence select wrong");
    a_blank: assert property (p_blank)
        else $error("pixels while blank forced");
    a_off: assert property (p_off)
        else $error("disabled outputs not idle");
    a_frame: assert property (p_frame)
        else $error("frame start pulse wrong");
    a_fetch: assert property (p_fetch)
        else $error("fetch count above limit");
    a_gamma: assert property (p_gamma)
        else $error("gamma enable wrong");
    a_pointer: assert property (p_pointer)
        else $error("pointer enable wrong");
    a_fmt: assert property (p_fmt)
        else $error("format selects wrong");
endmodule // lcdtoc_checker

bind lcdtoc_top lcdtoc_checker u_checker (
    .I_MCLK, .I_RESETN, .I_WB_CYC, .I_WB_STB, .I_WB_WE, .I_WB_ADR, .I_WB_SEL, .I_WB_DAT,
    .O_WB_ACK, .O_HSYNC, .O_VSYNC, .O_DE, .O_PCLK, .O_RGB, .O_POINTER_ON, .O_GAMMA_ON,
    .O_YUV_SEL, .O_FMT_UNDIV, .O_SEQ_SEL, .O_FETCH_LINES, .O_FRAME_START
);
`default_nettype wire

// ===== tb/lcdtoc_panel.sv
/* lcdtoc_panel: display panel sink measuring line timing and pixel colour.
   assumes the panel is told the sync and data-valid polarities. */
`timescale 1ns/1ps
`default_nettype none
module lcdtoc_panel (
    input  wire logic        i_clk,
    input  wire logic        i_rst_n,
    input  wire logic        i_hsync,
    input  wire logic        i_de,
    input  wire logic [23:0] i_rgb,
    input  wire logic        i_hpol,
    input  wire logic        i_dpol,
    output logic      [10:0] o_de_len,
    output logic      [10:0] o_hs_len,
    output logic      [23:0] o_rgb
);
    logic [10:0] de_cnt;
    logic [10:0] hs_cnt;
    // run lengths are latched when the active level ends
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            {de_cnt, hs_cnt, o_de_len, o_hs_len, o_rgb} <= '0;
        end else begin
            de_cnt <= (i_de ^ i_dpol) ? de_cnt + 11'h1 : 11'h0;
            hs_cnt <= (i_hsync ^ i_hpol) ? hs_cnt + 11'h1 : 11'h0;
            if (!(i_de ^ i_dpol) && de_cnt != 11'h0) begin
                o_de_len <= de_cnt;
            end
            if (!(i_hsync ^ i_hpol) && hs_cnt != 11'h0) begin
                o_hs_len <= hs_cnt;
            end
            if (i_de ^ i_dpol) begin
                o_rgb <= i_rgb;
            end
        end
    end
endmodule // lcdtoc_panel
`default_nettype wire

// ===== tb/testbench.sv
/* testbench: register table, output formats, raster timing and idle state.
   assumes lcdtoc_top, lcdtoc_panel and the bound checker are compiled first. */
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import lcdtoc_pkg::*;
    typedef struct packed {logic [7:0] a; logic [31:0] w; logic [31:0] e;} lcdtoc_row_s;
    logic mclk = 1'b0, rst_n = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [3:0] sel = 4'h0;
    logic [31:0] wdat = 32'h0000_0000, rdat, q;
    logic ack, hs, vs, de, pclk, ptr_on, gam_on, yuv, fmt, fstart;
    logic [23:0] rgb, prgb;
    logic [2:0] seq;
    logic [5:0] fetch;
    logic [10:0] de_len, hs_len;
    int err_total = 0, n_compared = 0, cycles = 0, n_frames = 0, f0, i, hi;
    lcdtoc_row_s rows [9] = '{
        '{OFF_MODE, 32'h7FFF_FFFF, 32'h5DD8_03E0},
        '{OFF_CLKCON, 32'hFFFF_FFFF, 32'h0000_201F},
        '{OFF_BGCOLOR, 32'hFFFF_FFFF, 32'hFFFF_FFFF},
        '{OFF_RES, 32'hFFFF_FFFF, 32'h07FF_07FF},
        '{OFF_FPORCH, 32'hFFFF_FFFF, 32'h07FF_07FF},
        '{OFF_SYNCW, 32'hFFFF_FFFF, 32'h07FF_07FF},
        '{OFF_BPORCH, 32'hFFFF_FFFF, 32'h07FF_07FF},
        '{OFF_POINTER, 32'hFFFF_FFFF, 32'h07FF_07FF},
        '{8'h40, 32'hFFFF_FFFF, 32'h0000_0000}};
    lcdtoc_top DUT (.I_MCLK(mclk), .I_RESETN(rst_n), .I_WB_CYC(cyc), .I_WB_STB(stb),
        .I_WB_WE(we), .I_WB_ADR(adr), .I_WB_SEL(sel), .I_WB_DAT(wdat), .O_WB_DAT(rdat),
        .O_WB_ACK(ack), .O_HSYNC(hs), .O_VSYNC(vs), .O_DE(de), .O_PCLK(pclk), .O_RGB(rgb),
        .O_POINTER_ON(ptr_on), .O_GAMMA_ON(gam_on), .O_YUV_SEL(yuv), .O_FMT_UNDIV(fmt),
        .O_SEQ_SEL(seq), .O_FETCH_LINES(fetch), .O_FRAME_START(fstart));
    lcdtoc_panel u_panel (.i_clk(mclk), .i_rst_n(rst_n), .i_hsync(hs), .i_de(de),
        .i_rgb(rgb), .i_hpol(1'b1), .i_dpol(1'b1), .o_de_len(de_len), .o_hs_len(hs_len),
        .o_rgb(prgb));
    always #5 mclk = ~mclk;
    task automatic complete_run();
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    always @(posedge mclk) begin
        cycles++;
        n_frames += (fstart === 1'b1);
        if (cycles == 20000) begin
            err_total++;
            complete_run();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            $display("Error at %0t: got %h expected %h", $time, got, exp);
            err_total++;
        end
    endtask
    task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d,
                        output logic [31:0] r);
        @(posedge mclk);
        {cyc, stb, we, adr, wdat, sel} <= {2'b11, w, a, d, 4'hF};
        // ack and data are read before this edge's own updates land
        do begin
            @(posedge mclk);
        end while (ack !== 1'b1);
        r = rdat;
        {cyc, stb} <= 2'b00;
    endtask
    initial begin
        repeat (4) @(posedge mclk);
        rst_n <= 1'b1;
        foreach (rows[k]) begin
            xfer(rows[k].a, 1'b0, 32'h0000_0000, q);
            chk(q, 32'h0000_0000);
        end
        foreach (rows[k]) begin
            xfer(rows[k].a, 1'b1, rows[k].w, q);
            xfer(rows[k].a, 1'b0, 32'h0000_0000, q);
            chk(q, rows[k].e);
        end
        chk({26'h0, fetch}, 32'h0000_0020);
        $display("test registers done");
        for (i = 0; i < 8; i++) begin
            xfer(OFF_MODE, 1'b1, {24'h0, i[2:0], 5'h0}, q);
            repeat (3) @(negedge mclk);
            chk({29'h0, seq}, (i >= 6) ? 32'(i) : 32'h0000_0000);
        end
        $display("test sequence codes done");
        xfer(OFF_RES, 1'b1, 32'h0002_0001, q);
        for (i = 0; i < 3; i++) begin
            xfer(8'(OFF_FPORCH + 4 * i), 1'b1, 32'h0001_0001, q);
        end
        xfer(OFF_CLKCON, 1'b1, 32'h0000_0001, q);
        xfer(OFF_BGCOLOR, 1'b1, 32'h1234_56FF, q);
        xfer(OFF_MODE, 1'b1, 32'hCC10_0000, q);
        f0 = n_frames;
        hi = 0;
        repeat (60) begin
            @(negedge mclk);
            hi += (vs === 1'b1);
        end
        chk(32'(hi), 32'h0000_000F);
        chk(32'(n_frames - f0), 32'h0000_0002);
        chk({21'h0, de_len}, 32'h0000_0002);
        chk({21'h0, hs_len}, 32'h0000_0001);
        chk({8'h0, prgb}, 32'h0012_3456);
        chk({30'h0, ptr_on, gam_on}, 32'h0000_0003);
        xfer(OFF_MODE, 1'b1, 32'hCC98_0000, q);
        hi = 0;
        repeat (60) begin
            @(negedge mclk);
            hi += (vs === 1'b1);
        end
        chk(32'(hi), 32'h0000_0003);
        chk({8'h0, prgb}, 32'h0000_0000);
        $display("test raster done");
        for (i = 4; i < 6; i++) begin
            xfer(OFF_CLKCON, 1'b1, 32'(i), q);
            repeat (20) @(negedge mclk);
            hi = 0;
            repeat (2 * i) begin
                @(negedge mclk);
                hi += (pclk === 1'b1);
            end
            chk(32'(hi), (i == 5) ? 32'h0000_0006 : 32'h0000_0004);
        end
        xfer(OFF_MODE, 1'b1, 32'h1C40_0000, q);
        repeat (5) @(negedge mclk);
        chk({4'h0, vs, hs, de, pclk, rgb}, 32'h0F00_0000);
        $display("test duty and idle done");
        @(posedge mclk);
        rst_n <= 1'b0;
        repeat (2) @(posedge mclk);
        rst_n <= 1'b1;
        xfer(OFF_MODE, 1'b0, 32'h0000_0000, q);
        chk(q, 32'h0000_0000);
        $display("test second reset done");
        complete_run();
    end
endmodule // testbench
`default_nettype wire
